// file: hdl/port_io_pkg.sv
// ****************************************
// constants for the six-pin port
// ****************************************
package port_io_pkg;

    // widths
    localparam int PIN_W = 6;
    localparam int BUS_AW = 8;
    localparam int BUS_DW = 8;

    // register offsets
    localparam logic [7:0] DATA_OFS = 8'h05;
    localparam logic [7:0] DIR_OFS = 8'h85;
    localparam logic [7:0] CFG_OFS = 8'h9f;
    localparam logic [7:0] MODIFY_OFS = 8'hf5;

    // reset values
    localparam logic [5:0] LATCH_RST = 6'h00;
    localparam logic [5:0] DIR_RST = 6'h3f;
    localparam logic [3:0] SELECT_RST = 4'h0;
    localparam logic JUSTIFY_RST = 1'b0;
    localparam logic [5:0] OTHER_RST_KEEP = 6'h10;

    // field positions
    localparam int TIMER_BIT = 4;
    localparam int SS_BIT = 5;
    localparam int REF_BIT = 3;
    localparam int JUSTIFY_BIT = 7;
    localparam int SELECT_LSB = 0;
    localparam int SELECT_W = 4;
    localparam int MOD_VAL_BIT = 3;
    localparam int MOD_SEL_W = 3;

    // analog pins per select code, one bit per pin
    localparam logic [5:0] ANALOG_MAP [16] = '{
        6'h2f, 6'h2f, 6'h2f, 6'h2f, 6'h0b, 6'h0b, 6'h00, 6'h00,
        6'h2f, 6'h2f, 6'h2f, 6'h2f, 6'h2f, 6'h0f, 6'h01, 6'h0d
    };

endpackage

// file: hdl/six_bit_io_port.sv
// Function
// - The port has six two-way pins with a latch and a direction bit each.
// - A direction bit of one turns the driver off so the pin is an input.
// - A direction bit of zero drives the pin from its latch bit.
// - Data reads return pin levels and data writes change only the latch.
// - Bit writes read the pins, change the target bit, store the whole latch.
// - Pin four is also the timer clock input and only ever pulls low.
// - Analog-capable pins follow the analog pin select field of the config.
// - After power-on the analog-capable pins are analog and read as zero.
// - Direction bits still steer the drivers of pins in analog use.
// - Power-on clears latch, others keep bit four, direction sets to ones.
// - Pin five is also the serial slave select input and an analog input.
// - Pin three is also an analog input or the converter reference input.
// - An enabled slave select takes precedence over the port driver on pin five.
`timescale 1ns/100ps

module six_bit_io_port
    import port_io_pkg::*;
(
    // clock and resets
    input wire logic clock,
    input wire logic arst_n,
    input wire logic otherReset,
    // register port
    input wire logic [BUS_AW-1:0] addr,
    input wire logic [BUS_DW-1:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [BUS_DW-1:0] rdData,
    // pins
    input wire logic [PIN_W-1:0] pinIn,
    output logic [PIN_W-1:0] pinOut,
    output logic [PIN_W-1:0] pinOe,
    // shared peripherals
    input wire logic slaveSelectEnable,
    output logic timerExternalClock,
    output logic slaveSelectLevel,
    output logic [PIN_W-1:0] analogSelect,
    output logic resultJustify
);

    // ****************************************
    // state
    // ****************************************
    logic [PIN_W-1:0] sync1_q;
    logic [PIN_W-1:0] sync1_d;
    logic [PIN_W-1:0] sync2_q;
    logic [PIN_W-1:0] sync2_d;
    logic [PIN_W-1:0] latch_q;
    logic [PIN_W-1:0] latch_d;
    logic [PIN_W-1:0] dir_q;
    logic [PIN_W-1:0] dir_d;
    logic [SELECT_W-1:0] select_q;
    logic [SELECT_W-1:0] select_d;
    logic justify_q;
    logic justify_d;
    logic [BUS_DW-1:0] rdData_q;
    logic [BUS_DW-1:0] rdData_d;
    logic [PIN_W-1:0] pinLevel;
    logic [MOD_SEL_W-1:0] modBit;

    // ****************************************
    // pin synchroniser
    // ****************************************
    always_comb
    begin
        sync1_d = pinIn;
        sync2_d = sync1_q;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
        end
        else
        begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    // ****************************************
    // analog selection and read value
    // ****************************************
    assign analogSelect = ANALOG_MAP[select_q];
    assign pinLevel = sync2_q & ~analogSelect;
    assign resultJustify = justify_q;
    assign timerExternalClock = sync2_q[TIMER_BIT];
    assign slaveSelectLevel = sync2_q[SS_BIT];
    assign modBit = wrData[MOD_SEL_W-1:0];

    // ****************************************
    // register next values
    // ****************************************
    always_comb
    begin
        latch_d = latch_q;
        dir_d = dir_q;
        select_d = select_q;
        justify_d = justify_q;
        rdData_d = 8'h00;
        if (otherReset)
        begin
            latch_d = latch_q & OTHER_RST_KEEP;
            dir_d = DIR_RST;
            select_d = SELECT_RST;
            justify_d = JUSTIFY_RST;
        end
        else if (wrStrobe)
        begin
            case (addr)
                DATA_OFS:
                begin
                    // every bit targeted, latch loaded from write data without reading pins
                    latch_d = wrData[PIN_W-1:0];
                end
                MODIFY_OFS:
                begin
                    latch_d = pinLevel;
                    if (modBit < 3'h6)
                    begin
                        latch_d[modBit] = wrData[MOD_VAL_BIT];
                    end
                end
                DIR_OFS:
                begin
                    dir_d = wrData[PIN_W-1:0];
                end
                CFG_OFS:
                begin
                    select_d = wrData[SELECT_LSB +: SELECT_W];
                    justify_d = wrData[JUSTIFY_BIT];
                end
                default:
                begin
                    latch_d = latch_q;
                end
            endcase
        end
        if (rdStrobe)
        begin
            case (addr)
                DATA_OFS:
                begin
                    rdData_d = {2'h0, pinLevel};
                end
                DIR_OFS:
                begin
                    rdData_d = {2'h0, dir_q};
                end
                CFG_OFS:
                begin
                    rdData_d = {justify_q, 3'h0, select_q};
                end
                default:
                begin
                    rdData_d = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            latch_q <= LATCH_RST;
            dir_q <= DIR_RST;
            select_q <= SELECT_RST;
            justify_q <= JUSTIFY_RST;
            rdData_q <= 8'h00;
        end
        else
        begin
            latch_q <= latch_d;
            dir_q <= dir_d;
            select_q <= select_d;
            justify_q <= justify_d;
            rdData_q <= rdData_d;
        end
    end

    assign rdData = rdData_q;

    // ****************************************
    // pin drivers
    // ****************************************
    for (genvar i = 0; i < PIN_W; i++)
    begin : g_pin
        if (i == TIMER_BIT)
        begin : g_drain
            assign pinOut[i] = 1'b0;
            assign pinOe[i] = ~dir_q[i] & ~latch_q[i];
        end
        else if (i == SS_BIT)
        begin : g_ss
            assign pinOut[i] = latch_q[i];
            assign pinOe[i] = ~dir_q[i] & ~slaveSelectEnable;
        end
        else
        begin : g_plain
            assign pinOut[i] = latch_q[i];
            assign pinOe[i] = ~dir_q[i];
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    sequence s_data_wr;
        wrStrobe && addr == DATA_OFS && !otherReset;
    endsequence

    sequence s_modify_bit1;
        wrStrobe && addr == MODIFY_OFS && !otherReset && modBit == 3'h1;
    endsequence

    sequence s_data_rd;
        rdStrobe && addr == DATA_OFS;
    endsequence

    property p_input_hiz;
        (pinOe & dir_q) == 6'h00;
    endproperty
    a_input_hiz: assert property (p_input_hiz)
        else $error("driver on while direction is input");

    property p_write_drives;
        s_data_wr ##1 !dir_q[0] |-> pinOe[0] && pinOut[0] == $past(wrData[0]);
    endproperty
    a_write_drives: assert property (p_write_drives)
        else $error("written latch not driven on pin");

    property p_read_levels;
        s_data_rd |=> rdData == {2'h0, $past(sync2_q) & ~$past(analogSelect)};
    endproperty
    a_read_levels: assert property (p_read_levels)
        else $error("data read not equal to pin levels");

    property p_modify;
        s_modify_bit1 |=> latch_q[1] == $past(wrData[MOD_VAL_BIT])
            && latch_q[0] == $past(pinLevel[0])
            && latch_q[5] == $past(pinLevel[5]);
    endproperty
    a_modify: assert property (p_modify)
        else $error("bit write did not merge pin levels");

    property p_open_drain;
        pinOe[TIMER_BIT] |-> !pinOut[TIMER_BIT] && !latch_q[TIMER_BIT];
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("timer pin driven high");

    property p_cfg_select;
        wrStrobe && addr == CFG_OFS && !otherReset
            |=> analogSelect == ANALOG_MAP[$past(wrData[3:0])];
    endproperty
    a_cfg_select: assert property (p_cfg_select)
        else $error("analog select not taken from config");

    property p_analog_zero;
        s_data_rd ##0 analogSelect[REF_BIT] |=> !rdData[REF_BIT];
    endproperty
    a_analog_zero: assert property (p_analog_zero)
        else $error("analog pin read as one");

    property p_analog_dir;
        analogSelect[0] && !dir_q[0] |-> pinOe[0];
    endproperty
    a_analog_dir: assert property (p_analog_dir)
        else $error("direction ignored on analog pin");

    property p_dir_upper;
        rdStrobe && addr == DIR_OFS
            |=> rdData[7:6] == 2'h0 && rdData[5:0] == $past(dir_q);
    endproperty
    a_dir_upper: assert property (p_dir_upper)
        else $error("direction read wrong");

    property p_other_reset;
        otherReset |=> dir_q == DIR_RST
            && latch_q[TIMER_BIT] == $past(latch_q[TIMER_BIT])
            && (latch_q & ~OTHER_RST_KEEP) == 6'h00;
    endproperty
    a_other_reset: assert property (p_other_reset)
        else $error("other reset values wrong");

    property p_ss_first;
        slaveSelectEnable |-> !pinOe[SS_BIT];
    endproperty
    a_ss_first: assert property (p_ss_first)
        else $error("port drives slave select pin");

endmodule

// file: dv/pin_far_side.sv
`timescale 1ns/100ps

module pin_far_side
    import port_io_pkg::*;
(
    // design side
    input wire logic [PIN_W-1:0] pinOut,
    input wire logic [PIN_W-1:0] pinOe,
    output logic [PIN_W-1:0] pinIn,
    // outside drivers
    input wire logic [PIN_W-1:0] extLevel
);
    // wire level per pin
    always_comb
    begin
        for (int i = 0; i < PIN_W; i++)
        begin
            pinIn[i] = pinOe[i] ? pinOut[i] : extLevel[i];
        end
    end
endmodule

// file: dv/six_bit_io_port_tb.sv
`timescale 1ns/100ps

module six_bit_io_port_tb
    import port_io_pkg::*;
;
    logic clock, arst_n, otherReset, wrStrobe, rdStrobe, rdSeen;
    logic slaveSelectEnable, timerExternalClock, slaveSelectLevel;
    logic resultJustify;
    logic [7:0] addr, wrData, rdData, r;
    logic [5:0] pinIn, pinOut, pinOe, analogSelect, extLevel;
    logic [5:0] dirQ, latchQ, lv;
    logic [3:0] code;
    logic [7:0] expQ[$];
    int err_count, samples_checked, cycles, seed;

    six_bit_io_port dut (.clock(clock), .arst_n(arst_n),
        .otherReset(otherReset), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .slaveSelectEnable(slaveSelectEnable),
        .timerExternalClock(timerExternalClock),
        .slaveSelectLevel(slaveSelectLevel),
        .analogSelect(analogSelect), .resultJustify(resultJustify));

    pin_far_side far (.pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn),
        .extLevel(extLevel));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [5:0] oeOf(input logic [5:0] d, l);
        logic [5:0] oe;
        oe = ~d;
        oe[4] = ~d[4] & ~l[4];
        oe[5] = oe[5] & ~slaveSelectEnable;
        return oe;
    endfunction

    function automatic logic [5:0] level(input logic [5:0] d, l, e);
        logic [5:0] oe;
        oe = oeOf(d, l);
        return (oe & l & 6'h2f) | (~oe & e);
    endfunction

    task automatic check(input logic [7:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, d);
        @(posedge clock);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clock);
        wrStrobe <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, e);
        @(posedge clock);
        expQ.push_back(e);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clock);
        rdStrobe <= 1'b0;
    endtask

    task automatic settle;
        repeat (4) @(posedge clock);
    endtask

    task automatic complete_run;
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ****************************************
    // clock, watcher, timeout
    // ****************************************
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    always @(posedge clock)
    begin
        if (rdSeen)
            check(rdData, expQ.pop_front());
        rdSeen <= rdStrobe;
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            complete_run();
        end
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial
    begin
        seed = 46401;
        err_count = 0;
        samples_checked = 0;
        arst_n = 1'b0;
        otherReset = 1'b0;
        addr = 8'h00;
        wrData = 8'h00;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        slaveSelectEnable = 1'b0;
        extLevel = 6'h15;
        latchQ = 6'h00;
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        rd(DIR_OFS, 8'h3f);
        rd(CFG_OFS, 8'h00);
        rd(DATA_OFS, 8'h10);
        check({2'b00, analogSelect}, 8'h2f);
        // every select code
        for (int c = 0; c < 16; c++)
        begin
            r = 8'($random(seed));
            extLevel <= r[5:0];
            wr(CFG_OFS, {r[7], 3'b111, c[3:0]});
            settle();
            check({2'b00, analogSelect}, {2'b00, ANALOG_MAP[c]});
            check({7'h00, resultJustify}, {7'h00, r[7]});
            rd(CFG_OFS, {r[7], 3'b000, c[3:0]});
            rd(DATA_OFS, {2'b00, r[5:0] & ~ANALOG_MAP[c]});
        end
        // direction, latch and drivers
        for (int k = 0; k < 16; k++)
        begin
            code = k[0] ? 4'h6 : (k[1] ? 4'h4 : 4'h0);
            slaveSelectEnable <= (code == 4'h4);
            r = 8'($random(seed));
            dirQ = r[5:0];
            r = 8'($random(seed));
            latchQ = r[5:0];
            r = 8'($random(seed));
            extLevel <= r[5:0];
            wr(CFG_OFS, {4'h0, code});
            wr(DIR_OFS, {2'b11, dirQ});
            wr(DATA_OFS, {2'b11, latchQ});
            settle();
            lv = level(dirQ, latchQ, extLevel);
            r = {2'b00, oeOf(dirQ, latchQ)};
            check({2'b00, pinOe}, r);
            check({2'b00, pinOut}, {2'b00, latchQ & 6'h2f});
            check({7'h00, timerExternalClock}, {7'h00, lv[4]});
            check({7'h00, slaveSelectLevel}, {7'h00, lv[5]});
            rd(DIR_OFS, {2'b00, dirQ});
            rd(DATA_OFS, {2'b00, lv & ~ANALOG_MAP[code]});
        end
        // single-bit writes over pin levels
        slaveSelectEnable <= 1'b0;
        wr(CFG_OFS, 8'h06);
        dirQ = 6'h03;
        for (int i = 0; i < 6; i++)
        begin
            r = 8'($random(seed));
            extLevel <= r[5:0];
            wr(DIR_OFS, {2'b00, dirQ});
            settle();
            latchQ = level(dirQ, latchQ, extLevel);
            latchQ[i] = r[6];
            wr(MODIFY_OFS, {4'h0, r[6], i[2:0]});
            settle();
            check({2'b00, pinOut}, {2'b00, latchQ & 6'h2f});
            check({2'b00, pinOe}, {2'b00, oeOf(dirQ, latchQ)});
        end
        // bit index above five keeps all pin levels
        latchQ = level(dirQ, latchQ, extLevel);
        wr(MODIFY_OFS, 8'h0f);
        settle();
        check({2'b00, pinOut}, {2'b00, latchQ & 6'h2f});
        // unmapped and write-only places
        rd(MODIFY_OFS, 8'h00);
        wr(8'h44, 8'hff);
        rd(8'h44, 8'h00);
        rd(DIR_OFS, {2'b00, dirQ});
        // warm reset keeps latch bit four
        wr(DATA_OFS, 8'h3f);
        wr(DIR_OFS, 8'h00);
        wr(CFG_OFS, 8'h8d);
        @(posedge clock);
        otherReset <= 1'b1;
        @(posedge clock);
        otherReset <= 1'b0;
        rd(DIR_OFS, 8'h3f);
        rd(CFG_OFS, 8'h00);
        wr(DIR_OFS, 8'h00);
        settle();
        check({2'b00, pinOe}, 8'h2f);
        check({2'b00, pinOut}, 8'h00);
        // power-on reset in mid-run
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (3) @(posedge clock);
        check({2'b00, pinOe}, 8'h00);
        check({2'b00, analogSelect}, 8'h2f);
        arst_n <= 1'b1;
        rd(DIR_OFS, 8'h3f);
        repeat (4) @(posedge clock);
        complete_run();
    end
endmodule
